// [design/rx_pins.v]
// Receive-side MII/RMII pin logic, straps and indicator routing
// Operation
// - MII nibble MSB on data line 3
// - Lines 0-1: nibble low bits or dibit
// - Error flag raised for errored frame
// - Error pin means LPI when valid low
// - Symbol mode: code-group MSB on line 4
// - Otherwise line 4 acts as error
// - Receive clock 25 or 2.5 MHz
// - Valid only while decoded data present
// - MII collision output follows medium collision
// - MII carrier output follows medium carrier
// - RMII carrier-valid while medium non-idle
// - 10BASE-T RMII data low until SFD
// - No echo of own transmit in 10BASE-T RMII half
// - Three address straps form management address
// - Three mode straps select default mode
// - Straps captured each reset, held after
// - Interface strap low MII, high RMII
// - Indicator 1 function chosen by select field
// - Interrupt defaults to transmit-error shared pin
// - Interrupt routable to indicator 1 or 2
// - Power event routable to ind1, ind2; line 2 route reaches no output pin
`timescale 1ns/1ps
`include "rx_pins_defs.vh"
module rx_pins #(
  parameter FIFO_DEPTH = 8
) (
  input wire mclk_i,
  input wire arst_n_i,
  // Straps, sampled after reset release
  input wire addr_strap_bit0_i,
  input wire addr_strap_bit1_i,
  input wire addr_strap_bit2_i,
  input wire opmode_strap_bit0_i,
  input wire opmode_strap_bit1_i,
  input wire opmode_strap_bit2_i,
  input wire reduced_iface_strap_i,
  input wire irq_pin_function_strap_i,
  // Receive symbol stream from the decoder
  input wire sym_valid_i,
  output wire sym_ready_o,
  input wire [4:0] sym_data_i,
  input wire sym_err_i,
  input wire sym_sof_i,
  input wire sym_eof_i,
  // Medium status, from another domain
  input wire medium_carrier_i,
  input wire medium_collision_i,
  input wire medium_lpi_i,
  input wire tx_active_i,
  // Configuration
  input wire speed_100_i,
  input wire full_duplex_i,
  input wire eee_enable_i,
  input wire symbol_mode_i,
  input wire [1:0] ind1_sel_i,
  input wire [1:0] ind2_sel_i,
  input wire [1:0] irq_route_i,
  input wire [1:0] pme_route_i,
  input wire link_activity_i,
  input wire irq_n_i,
  input wire power_event_n_i,
  // MAC-facing pins
  output reg rx_clk_o,
  output reg [3:0] rxd_o,
  output reg rxd4_rxer_o,
  output reg rx_dv_o,
  output reg col_o,
  output reg crs_o,
  output reg irq_out_n_o,
  output reg status_indicator_1_o,
  output reg status_indicator_2_o,
  output reg [2:0] phy_addr_o,
  output reg [2:0] opmode_o,
  output reg rmii_mode_o,
  output reg irq_pin_is_irq_o
);
  // ****************************************
  // Strap capture
  // ****************************************
  reg strap_done_q;
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      strap_done_q <= 1'b0;
      phy_addr_o <= 3'h0;
      opmode_o <= 3'h0;
      rmii_mode_o <= 1'b0;
      irq_pin_is_irq_o <= 1'b1;
    end
    else if (!strap_done_q)
    begin
      // First edge after release only; constants under reset
      strap_done_q <= 1'b1;
      phy_addr_o <= {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i};
      opmode_o <= {opmode_strap_bit2_i, opmode_strap_bit1_i, opmode_strap_bit0_i};
      rmii_mode_o <= reduced_iface_strap_i;
      irq_pin_is_irq_o <= irq_pin_function_strap_i;
    end
  end
  // ****************************************
  // Medium status synchronisers
  // ****************************************
  reg [2:0] crs_s_q;
  reg [2:0] col_s_q;
  reg [2:0] lpi_s_q;
  reg crs_f_q;
  reg col_f_q;
  reg lpi_f_q;
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      crs_s_q <= 3'h0;
      col_s_q <= 3'h0;
      lpi_s_q <= 3'h0;
      crs_f_q <= 1'b0;
      col_f_q <= 1'b0;
      lpi_f_q <= 1'b0;
    end
    else
    begin
      crs_s_q <= {crs_s_q[1:0], medium_carrier_i};
      col_s_q <= {col_s_q[1:0], medium_collision_i};
      lpi_s_q <= {lpi_s_q[1:0], medium_lpi_i};
      // Change accepted once stages two and three agree
      if (crs_s_q[1] == crs_s_q[2])
        crs_f_q <= crs_s_q[2];
      if (col_s_q[1] == col_s_q[2])
        col_f_q <= col_s_q[2];
      if (lpi_s_q[1] == lpi_s_q[2])
        lpi_f_q <= lpi_s_q[2];
    end
  end
  // ****************************************
  // Receive clock divider
  // ****************************************
  localparam integer HALF_100_I = `RXCLK_HALF_100;
  localparam integer HALF_10_I = `RXCLK_HALF_10;
  localparam [7:0] HALF_100 = HALF_100_I[7:0];
  localparam [7:0] HALF_10 = HALF_10_I[7:0];
  reg [7:0] div_q;
  wire [7:0] half_w = speed_100_i ? HALF_100 : HALF_10;
  wire toggle_w = (div_q >= half_w - 8'h01);
  // Outputs update with the falling edge so the MAC samples stable data on rising
  wire launch_w = toggle_w && rx_clk_o;
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_q <= 8'h00;
      rx_clk_o <= 1'b0;
    end
    else if (toggle_w)
    begin
      div_q <= 8'h00;
      rx_clk_o <= ~rx_clk_o;
    end
    else
      div_q <= div_q + 8'h01;
  end
  // ****************************************
  // Symbol buffer
  // ****************************************
  wire f_valid;
  wire f_ready;
  wire [7:0] f_data;
  // Own transmit echo in 10BASE-T RMII half duplex is dropped at the door
  wire echo_w = rmii_mode_o && !speed_100_i && !full_duplex_i && tx_active_i;
  wire push_valid = sym_valid_i && !echo_w;
  wire push_ready;
  assign sym_ready_o = push_ready || echo_w;
  rx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i({sym_eof_i, sym_sof_i, sym_err_i, sym_data_i}),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );
  // ****************************************
  // Frame delivery
  // ****************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PRE = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;
  reg [2:0] st_q;
  reg frame_err_q;
  reg [7:0] sfd_q;
  assign f_ready = launch_w;
  wire take_w = launch_w && f_valid;
  wire [1:0] dibit_w = f_data[1:0];
  wire [7:0] sfd_d = {dibit_w, sfd_q[7:2]};
  // 10BASE-T RMII hides preamble until SFD is seen
  wire hide_w = rmii_mode_o && !speed_100_i;
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q <= ST_IDLE;
      frame_err_q <= 1'b0;
      sfd_q <= 8'h00;
      rxd_o <= 4'h0;
      rxd4_rxer_o <= 1'b0;
      rx_dv_o <= 1'b0;
      col_o <= 1'b0;
      crs_o <= 1'b0;
    end
    else if (launch_w)
    begin
      col_o <= rmii_mode_o ? 1'b0 : col_f_q;
      rxd_o <= 4'h0;
      rx_dv_o <= 1'b0;
      rxd4_rxer_o <= eee_enable_i && lpi_f_q && !symbol_mode_i;
      case (st_q)
        ST_IDLE:
        begin
          frame_err_q <= 1'b0;
          sfd_q <= 8'h00;
          if (take_w && f_data[6])
            st_q <= hide_w ? ST_PRE : ST_DATA;
        end
        ST_PRE:
        begin
          if (take_w)
          begin
            sfd_q <= sfd_d;
            if (sfd_d == `SFD_BYTE)
              st_q <= ST_DATA;
            if (f_data[7])
              st_q <= ST_IDLE;
          end
        end
        default:
        begin
          if (take_w)
          begin
            rx_dv_o <= 1'b1;
            if (rmii_mode_o)
              rxd_o <= {2'h0, dibit_w};
            else
              rxd_o <= f_data[3:0];
            frame_err_q <= frame_err_q || f_data[5];
            if (symbol_mode_i)
              rxd4_rxer_o <= f_data[4];
            else
              rxd4_rxer_o <= frame_err_q || f_data[5];
            if (f_data[7])
              st_q <= ST_IDLE;
          end
        end
      endcase
      // RMII: carrier and valid share one pin while medium busy
      if (rmii_mode_o)
        crs_o <= crs_f_q || (st_q != ST_IDLE);
      else
        crs_o <= crs_f_q;
    end
  end
  // ****************************************
  // Interrupt and power-event routing
  // ****************************************
  function ind_fn;
    input [1:0] sel;
    input act;
    input spd;
    input irq;
    input pme;
    begin
      if (sel == `IND_SEL_ACT)
        ind_fn = act;
      else if (sel == `IND_SEL_SPD)
        ind_fn = spd;
      else if (sel == `IND_SEL_IRQ)
        ind_fn = irq;
      else
        ind_fn = pme;
    end
  endfunction
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_out_n_o <= 1'b1;
      status_indicator_1_o <= 1'b0;
      status_indicator_2_o <= 1'b0;
    end
    else
    begin
      // Default pin carries the interrupt only when routed there and strapped so
      irq_out_n_o <= (irq_route_i == `IRQ_ON_DEFAULT && irq_pin_is_irq_o) ? irq_n_i : 1'b1;
      status_indicator_1_o <= (irq_route_i == `IRQ_ON_IND1) ? irq_n_i :
        (pme_route_i == `PME_ON_IND1) ? power_event_n_i :
        ind_fn(ind1_sel_i, link_activity_i, speed_100_i, irq_n_i, power_event_n_i);
      status_indicator_2_o <= (irq_route_i == `IRQ_ON_IND2) ? irq_n_i :
        (pme_route_i == `PME_ON_IND2) ? power_event_n_i :
        ind_fn(ind2_sel_i, link_activity_i, speed_100_i, irq_n_i, power_event_n_i);
    end
  end
  // Line 2 is free in RMII; the power event is muxed onto rxd2_pme_n here, which drives no pin
  reg rxd2_pme_n;
  always @*
  begin
    rxd2_pme_n = rxd_o[2];
    if (rmii_mode_o && pme_route_i == `PME_ON_RXD2)
      rxd2_pme_n = power_event_n_i;
  end
endmodule // rx_pins

// [design/rx_pins_defs.vh]
// Constants for the receive-pin block of the 10/100 transceiver
`ifndef RX_PINS_DEFS_VH
`define RX_PINS_DEFS_VH
`define CLK_MHZ 100
`define RXCLK_100_MHZ_X10 250
`define RXCLK_10_MHZ_X10 25
`define RXCLK_HALF_100 ((`CLK_MHZ * 10) / (`RXCLK_100_MHZ_X10 * 2))
`define RXCLK_HALF_10 ((`CLK_MHZ * 10) / (`RXCLK_10_MHZ_X10 * 2))
`define SFD_BYTE 8'hAB
`define IND_SEL_ACT 2'h0
`define IND_SEL_SPD 2'h1
`define IND_SEL_IRQ 2'h2
`define IND_SEL_PME 2'h3
`define PME_ON_IND1 2'h0
`define PME_ON_IND2 2'h1
`define PME_ON_RXD2 2'h2
`define PME_ON_NONE 2'h3
`define IRQ_ON_DEFAULT 2'h0
`define IRQ_ON_IND1 2'h1
`define IRQ_ON_IND2 2'h2
`endif

// [design/rx_fifo.v]
// Small valid/ready FIFO for receive symbols
`timescale 1ns/1ps
module rx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk_i,
  input wire arst_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire [AW:0] fill = wr_q - rd_q;
  assign in_ready_o = (fill != DEPTH[AW:0]);
  assign out_valid_o = (fill != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_q[AW-1:0]];
  always @(posedge mclk_i)
  begin
    if (in_valid_i && in_ready_o)
      mem[wr_q[AW-1:0]] <= in_data_i;
  end
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid_i && in_ready_o)
        wr_q <= wr_q + 1'b1;
      if (out_valid_o && out_ready_i)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule // rx_fifo

// [tb/rx_pins_properties.sv]
// Checker watching the receive-pin block's ports
`timescale 1ns/1ps
module rx_pins_properties (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic addr_strap_bit0_i,
  input wire logic addr_strap_bit1_i,
  input wire logic addr_strap_bit2_i,
  input wire logic reduced_iface_strap_i,
  input wire logic speed_100_i,
  input wire logic medium_carrier_i,
  input wire logic medium_collision_i,
  input wire logic [1:0] irq_route_i,
  input wire logic [1:0] pme_route_i,
  input wire logic irq_n_i,
  input wire logic power_event_n_i,
  input wire logic rx_clk_o,
  input wire logic [3:0] rxd_o,
  input wire logic rx_dv_o,
  input wire logic col_o,
  input wire logic crs_o,
  input wire logic status_indicator_1_o,
  input wire logic status_indicator_2_o,
  input wire logic [2:0] phy_addr_o,
  input wire logic rmii_mode_o
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  a_addr_strap_latch: assert property ($rose(arst_n_i) |=> phy_addr_o ==
    $past({addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i})) else $error("address strap not latched");
  a_iface_strap_latch: assert property ($rose(arst_n_i) |=> rmii_mode_o ==
    $past(reduced_iface_strap_i)) else $error("interface strap not latched");
  a_rxclk_fast_half: assert property ($rose(rx_clk_o) && speed_100_i |-> ##2 $fell(rx_clk_o))
    else $error("fast receive clock half period wrong");
  a_rxclk_slow_half: assert property ($rose(rx_clk_o) && !speed_100_i |-> ##20 $fell(rx_clk_o))
    else $error("slow receive clock half period wrong");
  a_carrier_follow: assert property ($rose(medium_carrier_i) |-> ##[1:60] crs_o)
    else $error("carrier not reported");
  a_collision_follow: assert property ($rose(medium_collision_i) && !rmii_mode_o |-> ##[1:60] col_o)
    else $error("collision not reported");
  a_rxd_stable_sample: assert property ($rose(rx_clk_o) |-> $stable(rxd_o) && $stable(rx_dv_o))
    else $error("receive data moved at clock rise");
  a_irq_on_ind1: assert property (irq_route_i == 2'h1 |=> status_indicator_1_o == $past(irq_n_i))
    else $error("interrupt not on indicator 1");
  a_pme_on_ind2: assert property (pme_route_i == 2'h1 && irq_route_i != 2'h2 |=>
    status_indicator_2_o == $past(power_event_n_i)) else $error("power event not on indicator 2");
  c_frame: cover property ($rose(rx_dv_o));
  c_collision: cover property ($rose(col_o));
  c_irq_ind1: cover property (irq_route_i == 2'h1 && !irq_n_i);
endmodule // rx_pins_properties

// [tb/mac_rx_model.sv]
// Behavioural MAC receiver on the receive pins
`timescale 1ns/1ps
module mac_rx_model (
  input wire logic rx_clk_i,
  input wire logic [3:0] rxd_i,
  input wire logic rx_dv_i,
  input wire logic rxer_i,
  input wire logic rmii_i
);
  logic [3:0] got [$];
  int err_seen = 0;
  // Pins are stable at the rising edge, so sample there
  always @(posedge rx_clk_i)
  begin
    if (rx_dv_i === 1'b1)
    begin
      got.push_back(rmii_i ? {2'h0, rxd_i[1:0]} : rxd_i);
      // Error pin may be left open in RMII
      if (rxer_i === 1'b1 && !rmii_i)
        err_seen++;
    end
  end
endmodule // mac_rx_model

// [tb/test_rx_pins.sv]
// Self-checking bench for the receive-pin block
`timescale 1ns/1ps
module test_rx_pins;
  logic mclk_i = 1'b0, arst_n_i = 1'b0, sym_valid_i = 1'b0, sym_err_i = 1'b0, sym_sof_i = 1'b0, sym_eof_i = 1'b0;
  logic addr_strap_bit0_i = 1'b0, addr_strap_bit1_i = 1'b0, addr_strap_bit2_i = 1'b0;
  logic opmode_strap_bit0_i = 1'b0, opmode_strap_bit1_i = 1'b0, opmode_strap_bit2_i = 1'b0;
  logic reduced_iface_strap_i = 1'b0, irq_pin_function_strap_i = 1'b1, medium_carrier_i = 1'b0;
  logic medium_collision_i = 1'b0, medium_lpi_i = 1'b0, tx_active_i = 1'b0, speed_100_i = 1'b1;
  logic full_duplex_i = 1'b1, eee_enable_i = 1'b0, symbol_mode_i = 1'b0, link_activity_i = 1'b1;
  logic irq_n_i = 1'b1, power_event_n_i = 1'b1, refused = 1'b0;
  logic [4:0] sym_data_i = 5'h00;
  logic [1:0] ind1_sel_i = 2'h0, ind2_sel_i = 2'h1, irq_route_i = 2'h0, pme_route_i = 2'h3;
  wire logic sym_ready_o, rx_clk_o, rxd4_rxer_o, rx_dv_o, col_o, crs_o, irq_out_n_o, rmii_mode_o, irq_pin_is_irq_o;
  wire logic status_indicator_1_o, status_indicator_2_o;
  wire logic [3:0] rxd_o;
  wire logic [2:0] phy_addr_o, opmode_o;
  int errors = 0;
  int samples_checked = 0;
  rx_pins #(.FIFO_DEPTH(8)) DUT (.*);
  mac_rx_model mac (.rx_clk_i(rx_clk_o), .rxd_i(rxd_o), .rx_dv_i(rx_dv_o), .rxer_i(rxd4_rxer_o), .rmii_i(rmii_mode_o));
  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] a, input logic [2:0] m, input logic r, input logic s);
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i} <= a;
    {opmode_strap_bit2_i, opmode_strap_bit1_i, opmode_strap_bit0_i} <= m;
    reduced_iface_strap_i <= r;
    speed_100_i <= s;
    repeat (20) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    // Straps moving after release must not show
    {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i} <= ~a;
    {opmode_strap_bit2_i, opmode_strap_bit1_i, opmode_strap_bit0_i} <= ~m;
    reduced_iface_strap_i <= ~r;
    repeat (3) @(posedge mclk_i);
    chk(phy_addr_o, a);
    chk(opmode_o, m);
    chk(rmii_mode_o, r);
    chk(irq_pin_is_irq_o, irq_pin_function_strap_i);
  endtask
  task automatic push(input logic [4:0] d, input logic sof, input logic eof);
    int n;
    n = 0;
    sym_valid_i <= 1'b1;
    sym_data_i <= d;
    sym_sof_i <= sof;
    sym_eof_i <= eof;
    @(negedge mclk_i);
    while (sym_ready_o !== 1'b1 && n < 2000)
    begin
      refused = 1'b1;
      n++;
      @(negedge mclk_i);
    end
    @(posedge mclk_i);
  endtask
  task automatic frame(input int n, input logic rm);
    int w;
    logic [1:0] pre [8];
    pre = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2};
    mac.got.delete();
    push(5'h00, 1'b1, 1'b0);
    // Preamble then start byte, low dibit first
    for (int i = 0; i < 8 && rm; i++)
      push({3'h0, pre[i]}, 1'b0, 1'b0);
    for (int i = 0; i < n; i++)
      push(5'((i * 3 + 5) & (rm ? 3 : 15)), 1'b0, i == n - 1);
    sym_valid_i <= 1'b0;
    w = 0;
    while (mac.got.size() < n && w < 5000)
    begin
      @(posedge mclk_i);
      w++;
    end
    for (int i = 0; i < n; i++)
      chk(mac.got[i], 8'((i * 3 + 5) & (rm ? 3 : 15)));
  endtask
  task automatic route(input logic [1:0] ir, input logic [1:0] pr, input logic ex1, input logic ex2, input logic exi);
    irq_route_i <= ir;
    pme_route_i <= pr;
    repeat (3) @(posedge mclk_i);
    chk({status_indicator_1_o, status_indicator_2_o, irq_out_n_o}, {ex1, ex2, exi});
  endtask
  // ****************
  // Sequence
  // ****************
  initial
  begin
    do_reset(3'h5, 3'h3, 1'b0, 1'b1);
    frame(6, 1'b0);
    medium_carrier_i <= 1'b1;
    medium_collision_i <= 1'b1;
    repeat (80) @(posedge mclk_i);
    chk({col_o, crs_o}, 2'h3);
    medium_carrier_i <= 1'b0;
    medium_collision_i <= 1'b0;
    repeat (80) @(posedge mclk_i);
    chk({col_o, crs_o}, 2'h0);
    eee_enable_i <= 1'b1;
    medium_lpi_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    chk(rxd4_rxer_o, 1'b1);
    eee_enable_i <= 1'b0;
    medium_lpi_i <= 1'b0;
    irq_n_i <= 1'b0;
    power_event_n_i <= 1'b0;
    route(2'h1, 2'h1, 1'b0, 1'b0, 1'b1);
    route(2'h2, 2'h0, 1'b0, 1'b0, 1'b1);
    route(2'h0, 2'h3, 1'b1, 1'b1, 1'b0);
    do_reset(3'h2, 3'h4, 1'b0, 1'b0);
    frame(12, 1'b0);
    chk(refused, 1'b1);
    do_reset(3'h7, 3'h0, 1'b1, 1'b0);
    frame(5, 1'b1);
    report_and_stop;
  end
  initial
  begin
    #500000;
    errors++;
    report_and_stop;
  end
endmodule // test_rx_pins
bind rx_pins rx_pins_properties u_props (.*);
